// File: core/param_write_ctrl.sv
/*
  Request interpreter for single- and double-word parameter writes with
  echo replies. Assumes a byte receiver and transmitter on the same clock,
  a frame-end pulse after the last received byte, and drive state levels
  from logic on the same clock.
*/
// Overview of operation
// - Register address is group times 100 plus index
// - Reply echoes station, function, address, count, CRC
// - CRC sent low byte then high byte
// - Word order selected by configuration input
// - Zero-speed class writable only at zero speed
// - Stop-to-set class read-only while enabled
// - Anytime class writable after power-on
// - Immediate class writable always, applies at once
// - Reset-effective class applies after drive reset
// - Rated current needs password satisfied
// - Direction change blocks running until relearn
// - Single-word write echoes whole request
`default_nettype none
module param_write_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Received bytes
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic rx_frame_end,
  // Reply bytes
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_ready,
  // Configuration
  input wire logic [7:0] station_addr,
  input wire logic word_order_select,
  // Drive state
  input wire logic zero_speed,
  input wire logic drive_enabled,
  input wire logic power_on_done,
  input wire logic password_ok,
  input wire logic drive_reset,
  input wire logic relearn_done,
  // Parameter values in effect
  output logic [15:0] rated_current_param,
  output logic [15:0] rated_speed_param,
  output logic [15:0] max_speed_param,
  output logic [15:0] rotation_direction_param,
  output logic run_inhibit
);
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_DATA = 4'b0010,
    TX_CRC_WAIT = 4'b0100,
    TX_CRC = 4'b1000
  } tx_state_t;

  crc_if rx_crc ();
  crc_if tx_crc ();
  crc16_unit rx_crc_unit (.clk(clk), .rst(rst), .bus(rx_crc));
  crc16_unit tx_crc_unit (.clk(clk), .rst(rst), .bus(tx_crc));

  logic [12:0][7:0] buf_q, buf_d;
  logic [3:0] cnt_q, cnt_d;
  logic [3:0][15:0] stored_q, stored_d, active_q, active_d;
  logic inhibit_q, inhibit_d;
  tx_state_t state_q, state_d;
  logic [7:0] tx_byte_q, tx_byte_d;
  logic tx_valid_q, tx_valid_d;
  logic [3:0] tx_idx_q, tx_idx_d, tx_len_q, tx_len_d;
  logic tx_dw_q, tx_dw_d;

  logic eval, crc_good, is_dw, is_sw, frame_ok, hit, allowed, write_ok, accept;
  logic [15:0] reg_addr, data_hi_first, new_value;
  logic [1:0] hit_idx;

  // Request decode
  assign eval = rx_frame_end && (state_q == TX_IDLE);
  assign crc_good = (rx_crc.crc == param_write_pkg::CRC_RESIDUE);
  assign is_dw = (buf_q[param_write_pkg::POS_FUNC] == param_write_pkg::FC_WRITE_DOUBLE)
    && (cnt_q == param_write_pkg::DW_REQ_LEN)
    && ({buf_q[param_write_pkg::POS_COUNT_HI], buf_q[param_write_pkg::POS_COUNT_LO]}
        == param_write_pkg::DW_REG_COUNT)
    && (buf_q[param_write_pkg::POS_BYTE_COUNT] == param_write_pkg::DW_BYTE_COUNT);
  assign is_sw = (buf_q[param_write_pkg::POS_FUNC] == param_write_pkg::FC_WRITE_SINGLE)
    && (cnt_q == param_write_pkg::SW_REQ_LEN);
  assign frame_ok = crc_good && (buf_q[param_write_pkg::POS_STATION] == station_addr)
    && (is_dw || is_sw);
  assign reg_addr = {buf_q[param_write_pkg::POS_ADDR_HI], buf_q[param_write_pkg::POS_ADDR_LO]};
  assign data_hi_first = word_order_select
    ? {buf_q[param_write_pkg::POS_DW_DATA + 2], buf_q[param_write_pkg::POS_DW_DATA + 3]}
    : {buf_q[param_write_pkg::POS_DW_DATA], buf_q[param_write_pkg::POS_DW_DATA + 1]};
  assign new_value = is_dw ? data_hi_first
    : {buf_q[param_write_pkg::POS_SW_DATA], buf_q[param_write_pkg::POS_SW_DATA + 1]};

  // Address map and permission check
  always_comb begin
    hit = 1'b0;
    hit_idx = 2'h0;
    allowed = 1'b0;
    for (int i = 0; i < param_write_pkg::NUM_PARAMS; i++) begin
      if (reg_addr == param_write_pkg::param_reg_addr(param_write_pkg::PARAM_GROUP,
                                                      param_write_pkg::PARAM_INDEX[i])) begin
        hit = 1'b1;
        hit_idx = 2'(i);
        case (param_write_pkg::PARAM_SET[i])
          param_write_pkg::SET_ZERO_SPEED: allowed = zero_speed;
          param_write_pkg::SET_STOP: allowed = !drive_enabled;
          param_write_pkg::SET_ANYTIME: allowed = power_on_done;
          param_write_pkg::SET_IMMEDIATE: allowed = 1'b1;
          default: allowed = 1'b0;
        endcase
        if (i == param_write_pkg::RATED_CURRENT_IDX && !password_ok) begin
          allowed = 1'b0;
        end
      end
    end
  end
  assign write_ok = eval && frame_ok && hit && allowed;

  // Receive buffer and parameter store
  always_comb begin
    buf_d = buf_q;
    cnt_d = cnt_q;
    stored_d = stored_q;
    active_d = active_q;
    inhibit_d = inhibit_q;
    if (rx_valid && state_q == TX_IDLE && cnt_q != 4'hF) begin
      if (cnt_q < param_write_pkg::BUF_BYTES) begin
        buf_d[cnt_q] = rx_byte;
      end
      cnt_d = cnt_q + 4'h1;
    end
    if (rx_frame_end) begin
      cnt_d = 4'h0;
    end
    if (relearn_done) begin
      inhibit_d = 1'b0;
    end
    if (drive_reset) begin
      for (int i = 0; i < param_write_pkg::NUM_PARAMS; i++) begin
        if (param_write_pkg::PARAM_EFFECT[i] == param_write_pkg::EFFECT_RESET) begin
          active_d[i] = stored_q[i];
        end
      end
    end
    if (write_ok) begin
      stored_d[hit_idx] = new_value;
      if (param_write_pkg::PARAM_EFFECT[hit_idx] == param_write_pkg::EFFECT_IMMEDIATE) begin
        active_d[hit_idx] = new_value;
      end
      if (hit_idx == 2'(param_write_pkg::ROTATION_DIR_IDX) && new_value != stored_q[hit_idx]) begin
        inhibit_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_q <= '0;
      cnt_q <= 4'h0;
      inhibit_q <= 1'b0;
      for (int i = 0; i < param_write_pkg::NUM_PARAMS; i++) begin
        stored_q[i] <= param_write_pkg::PARAM_RESET[i];
        active_q[i] <= param_write_pkg::PARAM_RESET[i];
      end
    end else begin
      buf_q <= buf_d;
      cnt_q <= cnt_d;
      inhibit_q <= inhibit_d;
      stored_q <= stored_d;
      active_q <= active_d;
    end
  end

  assign rx_crc.init = rx_frame_end;
  assign rx_crc.valid = rx_valid && state_q == TX_IDLE;
  assign rx_crc.data = rx_byte;

  // Reply sequencer
  assign accept = tx_valid_q && tx_ready;
  always_comb begin
    state_d = state_q;
    tx_byte_d = tx_byte_q;
    tx_valid_d = tx_valid_q;
    tx_idx_d = tx_idx_q;
    tx_len_d = tx_len_q;
    tx_dw_d = tx_dw_q;
    case (state_q)
      TX_IDLE: begin
        if (write_ok) begin
          tx_byte_d = buf_q[0];
          tx_valid_d = 1'b1;
          tx_idx_d = 4'h1;
          tx_dw_d = is_dw;
          tx_len_d = is_dw ? param_write_pkg::DW_REPLY_HDR_LEN
                           : param_write_pkg::SW_REQ_LEN;
          state_d = TX_DATA;
        end
      end
      TX_DATA: begin
        if (accept) begin
          if (tx_idx_q < tx_len_q) begin
            tx_byte_d = buf_q[tx_idx_q];
            tx_idx_d = tx_idx_q + 4'h1;
          end else begin
            tx_valid_d = 1'b0;
            state_d = tx_dw_q ? TX_CRC_WAIT : TX_IDLE;
          end
        end
      end
      TX_CRC_WAIT: begin
        tx_byte_d = tx_crc.crc[7:0];
        tx_valid_d = 1'b1;
        tx_idx_d = 4'h0;
        state_d = TX_CRC;
      end
      TX_CRC: begin
        if (accept) begin
          if (tx_idx_q == 4'h0) begin
            tx_byte_d = tx_crc.crc[15:8];
            tx_idx_d = 4'h1;
          end else begin
            tx_valid_d = 1'b0;
            state_d = TX_IDLE;
          end
        end
      end
      default: begin
        tx_valid_d = 1'b0;
        state_d = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= TX_IDLE;
      tx_byte_q <= 8'h00;
      tx_valid_q <= 1'b0;
      tx_idx_q <= 4'h0;
      tx_len_q <= 4'h0;
      tx_dw_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tx_byte_q <= tx_byte_d;
      tx_valid_q <= tx_valid_d;
      tx_idx_q <= tx_idx_d;
      tx_len_q <= tx_len_d;
      tx_dw_q <= tx_dw_d;
    end
  end

  assign tx_crc.init = write_ok;
  assign tx_crc.valid = accept && state_q == TX_DATA;
  assign tx_crc.data = tx_byte_q;

  assign tx_byte = tx_byte_q;
  assign tx_valid = tx_valid_q;
  assign rated_current_param = active_q[0];
  assign rated_speed_param = active_q[1];
  assign max_speed_param = active_q[2];
  assign rotation_direction_param = active_q[3];
  assign run_inhibit = inhibit_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_bad_crc_silent: assert property (
    (eval && !crc_good) |=> !tx_valid_q [*2]) else $error("reply after bad CRC");
  a_reply_station: assert property (
    write_ok |=> tx_valid_q && tx_byte_q == $past(station_addr)) else $error("reply start wrong");
  a_denied_no_change: assert property (
    (eval && !write_ok) |=> $stable(stored_q)) else $error("denied write changed store");
  a_password_guard: assert property (
    (eval && hit_idx == 2'h0 && !password_ok) |=> stored_q[0] == $past(stored_q[0]))
    else $error("rated current written without password");
  a_enabled_locks: assert property (
    drive_enabled |=> $stable(stored_q)) else $error("stop-to-set written while enabled");
  a_word_order: assert property (
    (write_ok && is_dw) |=> stored_q[$past(hit_idx)] == ($past(word_order_select)
      ? {$past(buf_q[param_write_pkg::POS_DW_DATA + 2]),
         $past(buf_q[param_write_pkg::POS_DW_DATA + 3])}
      : {$past(buf_q[param_write_pkg::POS_DW_DATA]),
         $past(buf_q[param_write_pkg::POS_DW_DATA + 1])}))
    else $error("double word assembled in wrong order");
  a_apply_now: assert property (
    write_ok |=> active_q[$past(hit_idx)] == stored_q[$past(hit_idx)])
    else $error("immediate value not applied");
  a_dir_inhibit: assert property (
    (write_ok && hit_idx == 2'h3 && new_value != stored_q[3] && !relearn_done)
    |=> inhibit_q ##1 (inhibit_q || $past(relearn_done))) else $error("direction change not inhibited");
  a_crc_low_first: assert property (
    (state_q == TX_CRC_WAIT) |=> tx_valid_q && tx_byte_q == $past(tx_crc.crc[7:0]))
    else $error("CRC low byte not first");
endmodule : param_write_ctrl
`default_nettype wire

// File: shared/param_write_pkg.sv
/*
  Constants for the double-word parameter write interpreter: frame layout,
  function codes, CRC figures, parameter map, classes and reset values.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package param_write_pkg;
  // Function codes and fixed fields
  localparam logic [7:0] FC_WRITE_DOUBLE = 8'h10;
  localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
  localparam logic [15:0] DW_REG_COUNT = 16'h0002;
  localparam logic [7:0] DW_BYTE_COUNT = 8'h04;
  // Frame lengths in bytes
  localparam logic [3:0] DW_REQ_LEN = 4'hD;
  localparam logic [3:0] SW_REQ_LEN = 4'h8;
  localparam logic [3:0] DW_REPLY_HDR_LEN = 4'h6;
  localparam logic [3:0] BUF_BYTES = 4'hD;
  // Byte positions in a request
  localparam int POS_STATION = 0;
  localparam int POS_FUNC = 1;
  localparam int POS_ADDR_HI = 2;
  localparam int POS_ADDR_LO = 3;
  localparam int POS_COUNT_HI = 4;
  localparam int POS_COUNT_LO = 5;
  localparam int POS_BYTE_COUNT = 6;
  localparam int POS_DW_DATA = 7;
  localparam int POS_SW_DATA = 4;
  // CRC16, reflected form
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  // Address mapping: group times stride plus index
  localparam int GROUP_STRIDE = 100;
  localparam int NUM_PARAMS = 4;
  localparam int RATED_CURRENT_IDX = 0;
  localparam int ROTATION_DIR_IDX = 3;
  localparam logic [7:0] PARAM_GROUP = 8'h00;
  localparam logic [7:0] PARAM_INDEX [NUM_PARAMS] = '{8'h01, 8'h02, 8'h03, 8'h04};
  // Setting classes and effect classes
  typedef enum logic [1:0] {
    SET_ZERO_SPEED = 2'h0,
    SET_STOP = 2'h1,
    SET_ANYTIME = 2'h2,
    SET_IMMEDIATE = 2'h3
  } set_class_t;
  typedef enum logic {
    EFFECT_IMMEDIATE = 1'h0,
    EFFECT_RESET = 1'h1
  } effect_class_t;
  localparam set_class_t PARAM_SET [NUM_PARAMS] = '{SET_STOP, SET_STOP, SET_STOP, SET_STOP};
  localparam effect_class_t PARAM_EFFECT [NUM_PARAMS] =
    '{EFFECT_IMMEDIATE, EFFECT_IMMEDIATE, EFFECT_IMMEDIATE, EFFECT_IMMEDIATE};
  localparam logic [15:0] PARAM_RESET [NUM_PARAMS] = '{16'h003C, 16'h0BB8, 16'h0BB8, 16'h0001};

  function automatic logic [15:0] param_reg_addr(input logic [7:0] group,
                                                 input logic [7:0] index);
    param_reg_addr = 16'(int'(group) * GROUP_STRIDE + int'(index));
  endfunction : param_reg_addr
endpackage : param_write_pkg
`default_nettype wire

// File: shared/crc_if.sv
/*
  Byte-serial CRC16 link between the interpreter and its CRC engines.
  Assumes a single clock shared by both ends.
*/
`default_nettype none
interface crc_if;
  logic init;
  logic valid;
  logic [7:0] data;
  logic [15:0] crc;
  modport engine (input init, input valid, input data, output crc);
  modport user (output init, output valid, output data, input crc);
endinterface : crc_if
`default_nettype wire

// File: core/crc16_unit.sv
/*
  CRC16 engine: one byte per clock, registered result.
  Assumes init and valid come from logic on the same clock.
*/
`default_nettype none
module crc16_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Byte stream
  crc_if.engine bus
);
  logic [15:0] crc_q;
  logic [15:0] crc_d;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ param_write_pkg::CRC_POLY) : (r >> 1);
    end
    crc_step = r;
  endfunction : crc_step

  always_comb begin
    crc_d = crc_q;
    if (bus.valid) begin
      crc_d = crc_step(bus.init ? param_write_pkg::CRC_INIT : crc_q, bus.data);
    end else if (bus.init) begin
      crc_d = param_write_pkg::CRC_INIT;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_q <= param_write_pkg::CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign bus.crc = crc_q;
endmodule : crc16_unit
`default_nettype wire

// File: verification/modbus_master_model.sv
/*
  Behavioural serial master: sends request bytes one by one, then a frame end,
  and takes reply bytes with random stalls.
  Assumes the interpreter's byte ports on the same clock, inputs changed at
  the falling edge.
*/
`default_nettype none
module modbus_master_model (
  // Clock
  input wire logic clk,
  // Request bytes
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic rx_frame_end,
  // Reply flow
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    rx_frame_end = 1'b0;
    tx_ready = 1'b0;
  end

  // Prompt or slow acceptance of reply bytes
  always @(negedge clk) begin
    tx_ready <= ($urandom_range(3) != 0);
  end

  // Bytes in given order, released lines show the inverse value
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(negedge clk);
      rx_byte = b[i];
      rx_valid = 1'b1;
      @(negedge clk);
      rx_valid = 1'b0;
      rx_byte = ~b[i];
    end
    @(negedge clk);
    rx_frame_end = 1'b1;
    @(negedge clk);
    rx_frame_end = 1'b0;
  endtask : send
endmodule : modbus_master_model
`default_nettype wire

// File: verification/modbus_double_word_param_write_tb.sv
/*
  Self-checking bench for the parameter write interpreter.
  Assumes the master model drives the request side; replies are checked
  against a queue of expected bytes.
*/
`default_nettype none
module modbus_double_word_param_write_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst, rx_valid, rx_frame_end, tx_valid, tx_ready, run_inhibit, inh;
  logic [7:0] rx_byte, tx_byte, station_addr;
  logic word_order_select, zero_speed, drive_enabled, power_on_done;
  logic password_ok, drive_reset, relearn_done;
  logic [15:0] p [4];
  logic [15:0] mdl [4];
  logic [15:0] a, b;
  logic [7:0] exp_q[$];
  int fails, tests_run;

  param_write_ctrl uut (.clk(clk), .rst(rst), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_frame_end(rx_frame_end), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .station_addr(station_addr),
    .word_order_select(word_order_select), .zero_speed(zero_speed),
    .drive_enabled(drive_enabled), .power_on_done(power_on_done),
    .password_ok(password_ok), .drive_reset(drive_reset), .relearn_done(relearn_done),
    .rated_current_param(p[0]), .rated_speed_param(p[1]), .max_speed_param(p[2]),
    .rotation_direction_param(p[3]), .run_inhibit(run_inhibit));

  modbus_master_model master (.clk(clk), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_frame_end(rx_frame_end), .tx_ready(tx_ready));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    if (fails == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = param_write_pkg::CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ param_write_pkg::CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc16

  // Reply watcher
  always @(posedge clk) begin
    if (rst === 1'b0 && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exp_q.size() == 0)
        check("tx_unexpected", {8'h00, tx_byte}, 16'hFFFF);
      else
        check("tx_byte", {8'h00, tx_byte}, {8'h00, exp_q.pop_front()});
    end
  end

  task automatic req(input logic [7:0] fc, input logic [7:0] stn, input logic [15:0] adr,
                     input logic [15:0] w0, input logic [15:0] w1, input logic bad);
    logic [7:0] f[$];
    logic [15:0] c, v;
    logic ok;
    zero_speed = 1'($urandom);
    power_on_done = 1'($urandom);
    f = {stn, fc, adr[15:8], adr[7:0]};
    if (fc == param_write_pkg::FC_WRITE_DOUBLE)
      f = {f, 8'h00, 8'h02, 8'h04, w0[15:8], w0[7:0], w1[15:8], w1[7:0]};
    else
      f = {f, w0[15:8], w0[7:0]};
    c = crc16(f);
    f = {f, c[7:0] ^ {7'h00, bad}, c[15:8]};
    v = (fc == param_write_pkg::FC_WRITE_DOUBLE && word_order_select) ? w1 : w0;
    ok = !bad && stn == station_addr && adr >= 1 && adr <= 4 && !drive_enabled
         && (adr != 1 || password_ok);
    if (ok) begin
      if (fc == param_write_pkg::FC_WRITE_SINGLE) begin
        exp_q = f;
      end else begin
        exp_q = f[0:5];
        c = crc16(exp_q);
        exp_q = {exp_q, c[7:0], c[15:8]};
      end
      if (adr == 4 && v != mdl[3])
        inh = 1'b1;
      mdl[adr - 1] = v;
    end
    master.send(f);
    for (int n = 0; n < 300 && exp_q.size() != 0; n++)
      @(negedge clk);
    repeat (4) @(negedge clk);
    check("reply_left", 16'(exp_q.size()), 16'h0000);
    check("tx_valid", {15'h0000, tx_valid}, 16'h0000);
    for (int i = 0; i < 4; i++)
      check("param", p[i], mdl[i]);
    check("run_inhibit", {15'h0000, run_inhibit}, {15'h0000, inh});
  endtask : req

  initial begin
    #400us;
    fails++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    station_addr = 8'h00;
    word_order_select = 1'b0;
    zero_speed = 1'b0;
    drive_enabled = 1'b0;
    power_on_done = 1'b1;
    password_ok = 1'b1;
    drive_reset = 1'b0;
    relearn_done = 1'b0;
    inh = 1'b0;
    mdl = param_write_pkg::PARAM_RESET;
    void'($urandom(36787));
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    station_addr = 8'($urandom_range(247, 1));
    for (int i = 0; i < 4; i++)
      check("reset", p[i], mdl[i]);
    // Every parameter in both word orders
    for (int k = 0; k < 8; k++) begin
      word_order_select = k[0];
      a = 16'($urandom);
      b = 16'($urandom);
      if (k >= 6) begin
        a[15:1] = '0;
        b[15:1] = '0;
      end
      req(param_write_pkg::FC_WRITE_DOUBLE, station_addr, 16'(k / 2 + 1), a, b, 1'b0);
    end
    // Relearn clears run block, drive reset leaves values alone
    @(negedge clk);
    relearn_done = 1'b1;
    drive_reset = 1'b1;
    @(negedge clk);
    relearn_done = 1'b0;
    drive_reset = 1'b0;
    inh = 1'b0;
    repeat (2) @(negedge clk);
    check("run_inhibit", {15'h0000, run_inhibit}, 16'h0000);
    for (int i = 0; i < 4; i++)
      check("param", p[i], mdl[i]);
    // Refusals
    drive_enabled = 1'b1;
    req(param_write_pkg::FC_WRITE_DOUBLE, station_addr, 16'h0002, 16'h1234, 16'h5678, 1'b0);
    req(param_write_pkg::FC_WRITE_SINGLE, station_addr, 16'h0003, 16'h0BB9, 16'h0000, 1'b0);
    drive_enabled = 1'b0;
    password_ok = 1'b0;
    req(param_write_pkg::FC_WRITE_DOUBLE, station_addr, 16'h0001, 16'h0050, 16'h0050, 1'b0);
    password_ok = 1'b1;
    req(param_write_pkg::FC_WRITE_DOUBLE, station_addr, 16'h0002, 16'h0100, 16'h0100, 1'b1);
    req(param_write_pkg::FC_WRITE_DOUBLE, station_addr ^ 8'h01, 16'h0002, 16'h0101,
        16'h0101, 1'b0);
    req(param_write_pkg::FC_WRITE_DOUBLE, station_addr, 16'h0000, 16'h0102, 16'h0102, 1'b0);
    req(param_write_pkg::FC_WRITE_DOUBLE, station_addr, 16'h0005, 16'h0103, 16'h0103, 1'b0);
    req(param_write_pkg::FC_WRITE_DOUBLE, station_addr, 16'h0101, 16'h0104, 16'h0104, 1'b0);
    // Single-word echo, direction change through it
    req(param_write_pkg::FC_WRITE_SINGLE, station_addr, 16'h0004, {15'h0000, ~mdl[3][0]},
        16'h0000, 1'b0);
    req(param_write_pkg::FC_WRITE_SINGLE, station_addr, 16'h0002, 16'($urandom), 16'h0000,
        1'b0);
    wrap_up();
  end
endmodule : modbus_double_word_param_write_tb
`default_nettype wire
